// >>> common/adc_cfg_pkg.sv
// constants for the converter front-end configuration register bank
package adc_cfg_pkg;
  // ----------------------------------------------------------------
  // register offsets and widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] REF_AND_OUTPUT_FORMAT_OFS = 8'hC1;
  localparam logic [7:0] CHAN_A_INPUT_SPAN_OFS = 8'hC2;
  localparam logic [7:0] CHAN_B_INPUT_SPAN_OFS = 8'hC3;
  localparam logic [7:0] COMMON_MODE_AND_SLEEP_OFS = 8'hC4;
  localparam logic [7:0] GLOBAL_CM_OFS = 8'hC5;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_RESET = 16'h0000;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int REF_OFF_BIT = 11;
  localparam int LANES_BIT = 9;
  localparam int RATE_BIT = 8;
  localparam int SPAN_A_LSB = 8;
  localparam int SPAN_B_LSB = 4;
  localparam int CM_SPAN_B_LSB = 8;
  localparam int CM_SPAN_A_LSB = 6;
  localparam int CM_ON_B_BIT = 3;
  localparam int CM_ON_A_BIT = 2;
  localparam int SLEEP_BIT = 0;
  localparam int GLOBAL_CM_BIT = 4;
  // ----------------------------------------------------------------
  // writable masks (reserved bits store and read as zero)
  // ----------------------------------------------------------------
  localparam logic [15:0] FMT_MASK = 16'h0B00;
  localparam logic [15:0] SPAN_A_MASK = 16'h0F00;
  localparam logic [15:0] SPAN_B_MASK = 16'h00F0;
  localparam logic [15:0] CM_MASK = 16'h03CD;
  localparam logic [15:0] GLOBAL_MASK = 16'h0010;
  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SPAN_MAX_CODE = 4'h5;
  localparam logic [1:0] CM_HALF_SPAN = 2'h0;
  localparam logic [1:0] CM_6V = 2'h1;
  localparam logic [1:0] CM_12V = 2'h2;
endpackage : adc_cfg_pkg

// >>> core/adc_frontend_config_regs.sv
// configuration register bank for the dual converter front end
// Overview of operation
// - reference bit set turns internal reference off
// - lane bit clear: four lanes, A 3/2, B 1/0
// - lane bit set: two lanes, A 3, B 1
// - rate bit clear DDR, set SDR
// - channel A span codes zero to five
// - channel B span, same codes, bits 7-4
// - common-mode span per channel, B higher pair
// - per-channel common-mode control enable bits
// - bit zero puts whole device asleep
// - all five registers reset to zero
// - global bit gates per-channel common-mode settings
module adc_frontend_config_regs (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // register port
  input wire logic [adc_cfg_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [adc_cfg_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [adc_cfg_pkg::DATA_W-1:0] reg_rdata_out,
  output logic reg_addr_err_out,
  // reference and output format
  output logic internal_reference_off_out,
  output logic reference_io_pin_is_input_out,
  output logic lanes_two_out,
  output logic [3:0] lane_active_out,
  output logic [3:0] lane_is_chan_b_out,
  output logic single_data_rate_out,
  // input spans
  output logic [3:0] span_chan_a_out,
  output logic [3:0] span_chan_b_out,
  output logic span_code_reserved_out,
  // effective common-mode control
  output logic common_mode_ctrl_on_chan_a_out,
  output logic common_mode_ctrl_on_chan_b_out,
  output logic [1:0] common_mode_span_chan_a_out,
  output logic [1:0] common_mode_span_chan_b_out,
  output logic cm_code_reserved_out,
  // power
  output logic whole_device_sleep_out
);
  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire logic sel_fmt = hit(reg_addr_in, adc_cfg_pkg::REF_AND_OUTPUT_FORMAT_OFS);
  wire logic sel_spa = hit(reg_addr_in, adc_cfg_pkg::CHAN_A_INPUT_SPAN_OFS);
  wire logic sel_spb = hit(reg_addr_in, adc_cfg_pkg::CHAN_B_INPUT_SPAN_OFS);
  wire logic sel_cm = hit(reg_addr_in, adc_cfg_pkg::COMMON_MODE_AND_SLEEP_OFS);
  wire logic sel_gcm = hit(reg_addr_in, adc_cfg_pkg::GLOBAL_CM_OFS);
  wire logic sel_any = sel_fmt | sel_spa | sel_spb | sel_cm | sel_gcm;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [15:0] fmt_q;
  logic [15:0] fmt_d;
  logic [15:0] spa_q;
  logic [15:0] spa_d;
  logic [15:0] spb_q;
  logic [15:0] spb_d;
  logic [15:0] cm_q;
  logic [15:0] cm_d;
  logic [15:0] gcm_q;
  logic [15:0] gcm_d;

  // next values; reserved bits masked so they read as zero
  assign fmt_d = (reg_wr_in && sel_fmt) ? (reg_wdata_in & adc_cfg_pkg::FMT_MASK) : fmt_q;
  assign spa_d = (reg_wr_in && sel_spa) ? (reg_wdata_in & adc_cfg_pkg::SPAN_A_MASK) : spa_q;
  assign spb_d = (reg_wr_in && sel_spb) ? (reg_wdata_in & adc_cfg_pkg::SPAN_B_MASK) : spb_q;
  assign cm_d = (reg_wr_in && sel_cm) ? (reg_wdata_in & adc_cfg_pkg::CM_MASK) : cm_q;
  assign gcm_d = (reg_wr_in && sel_gcm) ? (reg_wdata_in & adc_cfg_pkg::GLOBAL_MASK) : gcm_q;

  // reference and output format register, zero after reset
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      fmt_q <= adc_cfg_pkg::REG_RESET;
    end else begin
      fmt_q <= fmt_d;
    end
  end

  // channel A span register, zero after reset
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      spa_q <= adc_cfg_pkg::REG_RESET;
    end else begin
      spa_q <= spa_d;
    end
  end

  // channel B span register, zero after reset
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      spb_q <= adc_cfg_pkg::REG_RESET;
    end else begin
      spb_q <= spb_d;
    end
  end

  // common-mode and sleep register, zero after reset
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cm_q <= adc_cfg_pkg::REG_RESET;
    end else begin
      cm_q <= cm_d;
    end
  end

  // global common-mode register, zero after reset
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      gcm_q <= adc_cfg_pkg::REG_RESET;
    end else begin
      gcm_q <= gcm_d;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (sel_fmt) rd_mux = fmt_q;
    if (sel_spa) rd_mux = spa_q;
    if (sel_spb) rd_mux = spb_q;
    if (sel_cm) rd_mux = cm_q;
    if (sel_gcm) rd_mux = gcm_q;
  end

  // read data for one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 16'h0000;
      reg_addr_err_out <= 1'b0;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 16'h0000;
      reg_addr_err_out <= (reg_rd_in | reg_wr_in) & ~sel_any;
    end
  end

  // ----------------------------------------------------------------
  // format decode
  // ----------------------------------------------------------------
  wire logic lanes2 = fmt_q[adc_cfg_pkg::LANES_BIT];
  assign internal_reference_off_out = fmt_q[adc_cfg_pkg::REF_OFF_BIT];
  assign reference_io_pin_is_input_out = fmt_q[adc_cfg_pkg::REF_OFF_BIT];
  assign lanes_two_out = lanes2;
  // lane order {three,two,one,zero}; A on three/two, B on one/zero
  assign lane_active_out = lanes2 ? 4'hA : 4'hF;
  assign lane_is_chan_b_out = 4'h3;
  assign single_data_rate_out = fmt_q[adc_cfg_pkg::RATE_BIT];

  // ----------------------------------------------------------------
  // code checks shared by both channels
  // ----------------------------------------------------------------
  // span codes above the top defined code have no meaning
  function automatic logic span_undefined(input logic [3:0] code);
    span_undefined = (code > adc_cfg_pkg::SPAN_MAX_CODE);
  endfunction : span_undefined

  // the all-ones common-mode code has no meaning
  function automatic logic cm_undefined(input logic [1:0] code);
    cm_undefined = &code;
  endfunction : cm_undefined

  // ----------------------------------------------------------------
  // span decode
  // ----------------------------------------------------------------
  assign span_chan_a_out = spa_q[adc_cfg_pkg::SPAN_A_LSB +: 4];
  assign span_chan_b_out = spb_q[adc_cfg_pkg::SPAN_B_LSB +: 4];
  // either channel holding an undefined span code raises the flag
  assign span_code_reserved_out = span_undefined(span_chan_a_out) |
                                  span_undefined(span_chan_b_out);

  // ----------------------------------------------------------------
  // common-mode decode, gated by the global bit
  // ----------------------------------------------------------------
  wire logic gcm_on = gcm_q[adc_cfg_pkg::GLOBAL_CM_BIT];
  wire logic [1:0] cm_a_raw = cm_q[adc_cfg_pkg::CM_SPAN_A_LSB +: 2];
  wire logic [1:0] cm_b_raw = cm_q[adc_cfg_pkg::CM_SPAN_B_LSB +: 2];
  assign common_mode_ctrl_on_chan_a_out = gcm_on & cm_q[adc_cfg_pkg::CM_ON_A_BIT];
  assign common_mode_ctrl_on_chan_b_out = gcm_on & cm_q[adc_cfg_pkg::CM_ON_B_BIT];
  assign common_mode_span_chan_a_out = gcm_on ? cm_a_raw : adc_cfg_pkg::CM_12V;
  assign common_mode_span_chan_b_out = gcm_on ? cm_b_raw : adc_cfg_pkg::CM_12V;
  // raw codes are checked, so the flag works with the global bit clear
  assign cm_code_reserved_out = cm_undefined(cm_a_raw) | cm_undefined(cm_b_raw);

  // power-down
  assign whole_device_sleep_out = cm_q[adc_cfg_pkg::SLEEP_BIT];
endmodule : adc_frontend_config_regs

// >>> dv/adc_cfg_asserts.sv
// port assertions for the configuration register bank
module adc_cfg_chk (
  input wire logic sys_clk_in, sys_rst_in, reg_wr_in, reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in, reg_rdata_out,
  input wire logic internal_reference_off_out, lanes_two_out, single_data_rate_out,
  input wire logic [3:0] lane_active_out, span_chan_a_out, span_chan_b_out,
  input wire logic whole_device_sleep_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence wr_at(logic [7:0] a); reg_wr_in && reg_addr_in == a; endsequence
  sequence rd_at(logic [7:0] a); reg_rd_in && reg_addr_in == a; endsequence
  a_ref_select:
    assert property (wr_at(8'hC1) |=> internal_reference_off_out == $past(reg_wdata_in[11]))
    else $error("reference select wrong");
  a_lane_map:
    assert property (wr_at(8'hC1) |=> lanes_two_out == $past(reg_wdata_in[9]) &&
      lane_active_out == ($past(reg_wdata_in[9]) ? 4'hA : 4'hF)) else $error("lane map wrong");
  a_rate_select:
    assert property (wr_at(8'hC1) |=> single_data_rate_out == $past(reg_wdata_in[8]))
    else $error("rate select wrong");
  a_span_a:
    assert property (wr_at(8'hC2) |=> span_chan_a_out == $past(reg_wdata_in[11:8]))
    else $error("span a wrong");
  a_span_b:
    assert property (wr_at(8'hC3) |=> span_chan_b_out == $past(reg_wdata_in[7:4]))
    else $error("span b wrong");
  a_sleep_bit:
    assert property (wr_at(8'hC4) |=> whole_device_sleep_out == $past(reg_wdata_in[0]))
    else $error("sleep bit wrong");
  a_cm_readback:
    assert property (wr_at(8'hC4) ##1 rd_at(8'hC4) |=>
      reg_rdata_out == ($past(reg_wdata_in, 2) & 16'h03CD)) else $error("readback wrong");
  a_reset_clear:
    assert property (@(posedge sys_clk_in) disable iff (1'b0) $fell(sys_rst_in) |->
      reg_rdata_out == 16'h0000 && !whole_device_sleep_out && span_chan_a_out == 4'h0 &&
      !internal_reference_off_out && !lanes_two_out && !single_data_rate_out &&
      span_chan_b_out == 4'h0) else $error("reset value wrong");
endmodule : adc_cfg_chk
bind adc_frontend_config_regs adc_cfg_chk chk (.sys_clk_in, .sys_rst_in, .reg_wr_in,
  .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .internal_reference_off_out,
  .lanes_two_out, .single_data_rate_out, .lane_active_out, .span_chan_a_out,
  .span_chan_b_out, .whole_device_sleep_out);

// >>> dv/testbench.sv
// self-checking bench for the configuration register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, wr = 0, rd = 0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata;
  logic ref_off, ref_pin, two, sdr, err, sres, cres, on_a, on_b, sleep;
  logic [3:0] act, isb, sa, sb;
  logic [1:0] ca, cb;
  int mismatches = 0, cmp_count = 0;
  adc_frontend_config_regs dut (.sys_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .reg_addr_err_out(err), .internal_reference_off_out(ref_off),
    .reference_io_pin_is_input_out(ref_pin), .lanes_two_out(two), .lane_active_out(act),
    .lane_is_chan_b_out(isb), .single_data_rate_out(sdr), .span_chan_a_out(sa),
    .span_chan_b_out(sb), .span_code_reserved_out(sres), .common_mode_ctrl_on_chan_a_out(on_a),
    .common_mode_ctrl_on_chan_b_out(on_b), .common_mode_span_chan_a_out(ca),
    .common_mode_span_chan_b_out(cb), .cm_code_reserved_out(cres),
    .whole_device_sleep_out(sleep));
  always #2 clk = ~clk;
  task automatic check(input string n, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  // one write strobe, returns on the edge that took it
  task automatic wr_to(input logic [7:0] a, input logic [15:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_to
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check("rdata", rdata, exp);
    @(posedge clk);
  endtask : rd_chk
  task automatic t_reset;
    for (int i = 1; i < 6; i++) rd_chk(8'hC0 + 8'(i), 16'h0000);
    check("rst_out", {ref_off, two, sdr, sleep, on_a, on_b, sa, sb, 2'b00}, 16'h0000);
    check("rst_cm", {12'h000, ca, cb}, 16'h000A);
    $display("done reset");
  endtask : t_reset
  task automatic t_format;
    wr_to(8'hC1, 16'hFFFF);
    #1 check("fmt", {ref_off, ref_pin, two, sdr, act, isb}, 16'h0FA3);
    @(posedge clk);
    rd_chk(8'hC1, 16'h0B00);
    wr_to(8'hC1, 16'h0000);
    #1 check("four", {two, sdr, act}, 16'h000F);
    @(posedge clk);
    $display("done format");
  endtask : t_format
  task automatic t_spans;
    logic [3:0] c;
    for (int i = 0; i < 7; i++) begin
      c = 4'(i);
      wr_to(8'hC2, {4'h0, c, 8'h00});
      @(posedge clk);
      wr_to(8'hC3, {8'h00, c, 4'h0});
      #1 check("spans", {sa, sb, 7'h00, sres}, {c, c, 7'h00, i > 5});
      @(posedge clk);
    end
    $display("done spans");
  endtask : t_spans
  task automatic t_cm;
    wr_to(8'hC4, 16'hFFFF);
    rd_chk(8'hC4, 16'h03CD);
    check("cm_res", cres, 16'h0001);
    check("cm_gated", {on_a, on_b, ca, cb}, 16'h000A);
    wr_to(8'hC4, 16'h024D);
    @(posedge clk);
    wr_to(8'hC5, 16'h0010);
    #1 check("cm_on", {on_a, on_b, ca, cb, sleep, cres}, 16'h00DA);
    @(posedge clk);
    wr_to(8'hC4, 16'h0000);
    #1 check("wake", sleep, 16'h0000);
    @(posedge clk);
    $display("done cm");
  endtask : t_cm
  task automatic t_unmapped;
    wr_to(8'hC0, 16'hFFFF);
    #1 check("err", err, 16'h0001);
    @(posedge clk);
    rd_chk(8'hC0, 16'h0000);
    $display("done unmapped");
  endtask : t_unmapped
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  // watchdog against a hung run
  initial begin
    #100000;
    mismatches++;
    results();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_format();
    t_spans();
    t_cm();
    t_unmapped();
    results();
  end
endmodule : testbench
